//--- hdl/quad_switch_pkg.sv
// constants and types shared by the quad switch serial diagnosis logic
package quad_switch_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int CHANNELS = 4;
  localparam int BYTE_W = 8;
  localparam int CODE_W = 2;
  localparam int CMD_HI = 7;
  localparam int CMD_LO = 4;
  localparam logic [3:0] BIT_CNT_FULL = 4'h8;
  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;

  // ----------------------------------------
  // command words, upper nibble of the input byte
  // ----------------------------------------
  localparam logic [3:0] CMD_DIAG_ONLY = 4'h0;
  localparam logic [3:0] CMD_READ_BACK = 4'hc;
  localparam logic [3:0] CMD_ECHO = 4'ha;
  localparam logic [3:0] CMD_OR = 4'h3;
  localparam logic [3:0] CMD_AND = 4'hf;

  // ----------------------------------------
  // two-bit diagnosis codes, first bit in [1]
  // ----------------------------------------
  localparam logic [1:0] CODE_NORMAL = 2'h3;
  localparam logic [1:0] CODE_OVERLOAD = 2'h2;
  localparam logic [1:0] CODE_OPEN_LOAD = 2'h1;
  localparam logic [1:0] CODE_SHORT_GND = 2'h0;

  // ----------------------------------------
  // master-side settling time between the two diagnosis frames
  // ----------------------------------------
  localparam int SETTLE_TIME_US = 150;

  typedef enum logic [2:0] {
    CMD_KIND_DIAG,
    CMD_KIND_READ_BACK,
    CMD_KIND_ECHO,
    CMD_KIND_OR,
    CMD_KIND_AND,
    CMD_KIND_OTHER
  } cmd_kind_t;

  typedef enum logic [1:0] {
    FRAME_FULL_DIAG,
    FRAME_READ_BACK,
    FRAME_ECHO
  } frame_mode_t;

endpackage

//--- hdl/quad_switch_spi_diagnosis.sv
// serial command latching and diagnosis readout of a four-channel low-side switch
`timescale 1ns/10ps

// Functional notes
// - unknown command keeps the latched AND or OR mode
// - fault pin pulled low on any error
// - fault codes latched, newer error overwrites
// - serial output released while select high
// - diagnosis shifted out while select low
// - select rising edge clears error registers
// - full diagnosis: two bits per channel
// - normal channel reports HH
// - current limitation reports HL
// - open load reports LH
// - short to ground reports LL
// - clock low at select edges; sample falling
// - select rising edge loads output control
// - upper nibble selects the function
// - reset selects OR combining mode
module quad_switch_spi_diagnosis #(
  parameter int CHANNELS = quad_switch_pkg::CHANNELS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic parallel_input_ch1,
  input wire logic parallel_input_ch2,
  input wire logic parallel_input_ch3,
  input wire logic parallel_input_ch4,
  input wire logic [CHANNELS-1:0] overload_det,
  input wire logic [CHANNELS-1:0] open_load_det,
  input wire logic [CHANNELS-1:0] short_gnd_det,
  output logic so_out,
  output logic so_oe,
  output logic fault_out,
  output logic fault_oe,
  output logic [CHANNELS-1:0] channel_on,
  output logic and_mode
);

  // ----------------------------------------
  // decoding
  // ----------------------------------------
  function automatic quad_switch_pkg::cmd_kind_t cmd_kind(input logic [3:0] cmd);
    case (cmd)
      quad_switch_pkg::CMD_DIAG_ONLY: cmd_kind = quad_switch_pkg::CMD_KIND_DIAG;
      quad_switch_pkg::CMD_READ_BACK: cmd_kind = quad_switch_pkg::CMD_KIND_READ_BACK;
      quad_switch_pkg::CMD_ECHO: cmd_kind = quad_switch_pkg::CMD_KIND_ECHO;
      quad_switch_pkg::CMD_OR: cmd_kind = quad_switch_pkg::CMD_KIND_OR;
      quad_switch_pkg::CMD_AND: cmd_kind = quad_switch_pkg::CMD_KIND_AND;
      default: cmd_kind = quad_switch_pkg::CMD_KIND_OTHER;
    endcase
  endfunction

  // overload wins over short, short over open load when several detectors fire
  function automatic logic [1:0] fault_code(input logic ovl, input logic opn, input logic sgnd);
    if (ovl) begin
      fault_code = quad_switch_pkg::CODE_OVERLOAD;
    end else if (sgnd) begin
      fault_code = quad_switch_pkg::CODE_SHORT_GND;
    end else if (opn) begin
      fault_code = quad_switch_pkg::CODE_OPEN_LOAD;
    end else begin
      fault_code = quad_switch_pkg::CODE_NORMAL;
    end
  endfunction

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  localparam int SYNC_W = 3 + 4 + 3 * CHANNELS;
  logic [SYNC_W-1:0] sync1_r, sync2_r;
  logic cs_prev_r, sclk_prev_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // select bit resets to its idle high level, no false edge after reset
      sync1_r <= {1'b1, {(SYNC_W-1){1'b0}}};
      sync2_r <= {1'b1, {(SYNC_W-1){1'b0}}};
      cs_prev_r <= 1'b1;
      sclk_prev_r <= 1'b0;
    end else begin
      sync1_r <= {cs_n, sclk, si, parallel_input_ch4, parallel_input_ch3,
                  parallel_input_ch2, parallel_input_ch1, overload_det,
                  open_load_det, short_gnd_det};
      sync2_r <= sync1_r;
      cs_prev_r <= sync2_r[SYNC_W-1];
      sclk_prev_r <= sync2_r[SYNC_W-2];
    end
  end

  logic cs_s, sclk_s, si_s;
  logic [CHANNELS-1:0] par_s, ovl_s, opn_s, sgnd_s;
  assign cs_s = sync2_r[SYNC_W-1];
  assign sclk_s = sync2_r[SYNC_W-2];
  assign si_s = sync2_r[SYNC_W-3];
  assign par_s = sync2_r[3*CHANNELS +: CHANNELS];
  assign ovl_s = sync2_r[2*CHANNELS +: CHANNELS];
  assign opn_s = sync2_r[CHANNELS +: CHANNELS];
  assign sgnd_s = sync2_r[0 +: CHANNELS];

  logic cs_fall, cs_rise, sclk_fall, sclk_rise;
  assign cs_fall = cs_prev_r && !cs_s;
  assign cs_rise = !cs_prev_r && cs_s;
  // sclk is low at select edges, so edges only count inside a frame
  assign sclk_fall = !cs_s && sclk_prev_r && !sclk_s;
  assign sclk_rise = !cs_s && !sclk_prev_r && sclk_s;

  // ----------------------------------------
  // diagnosis registers
  // ----------------------------------------
  logic [CHANNELS*2-1:0] diag_r, diag_nxt;
  logic [CHANNELS-1:0] det_now;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_diag
      assign det_now[g] = ovl_s[g] | opn_s[g] | sgnd_s[g];
      always_comb begin
        diag_nxt[2*g +: 2] = diag_r[2*g +: 2];
        if (cs_rise) begin
          diag_nxt[2*g +: 2] = quad_switch_pkg::CODE_NORMAL;
        end
        // a fault present in the clearing cycle is kept, set beats clear
        if (det_now[g]) begin
          diag_nxt[2*g +: 2] = fault_code(ovl_s[g], opn_s[g], sgnd_s[g]);
        end
      end
    end
  endgenerate

  logic any_fault;
  always_comb begin
    any_fault = 1'b0;
    for (int i = 0; i < CHANNELS; i++) begin
      if (diag_r[2*i +: 2] != quad_switch_pkg::CODE_NORMAL) begin
        any_fault = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // serial frame and command state
  // ----------------------------------------
  logic [quad_switch_pkg::BYTE_W-1:0] rx_r, rx_nxt, tx_r, tx_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic so_r, so_nxt;
  logic and_r, and_nxt;
  logic [CHANNELS-1:0] data_r, data_nxt, on_r, on_nxt;
  quad_switch_pkg::frame_mode_t mode_r, mode_nxt;
  logic [CHANNELS-1:0] flag_bits;

  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      flag_bits[i] = (diag_r[2*i +: 2] == quad_switch_pkg::CODE_NORMAL);
    end
  end

  always_comb begin
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    bit_cnt_nxt = bit_cnt_r;
    so_nxt = so_r;
    and_nxt = and_r;
    data_nxt = data_r;
    mode_nxt = mode_r;
    if (cs_fall) begin
      bit_cnt_nxt = quad_switch_pkg::BIT_CNT_ZERO;
      if (mode_r == quad_switch_pkg::FRAME_READ_BACK) begin
        tx_nxt = {par_s, flag_bits};
      end else begin
        tx_nxt = diag_r;
      end
      so_nxt = tx_nxt[quad_switch_pkg::BYTE_W-1];
    end
    if (sclk_fall) begin
      rx_nxt = {rx_r[quad_switch_pkg::BYTE_W-2:0], si_s};
      if (bit_cnt_r != quad_switch_pkg::BIT_CNT_FULL) begin
        bit_cnt_nxt = bit_cnt_r + 4'h1;
      end
    end
    if (sclk_rise) begin
      tx_nxt = {tx_r[quad_switch_pkg::BYTE_W-2:0], 1'b0};
      so_nxt = tx_nxt[quad_switch_pkg::BYTE_W-1];
    end
    if (cs_rise) begin
      // read-back and echo last for one frame only
      mode_nxt = quad_switch_pkg::FRAME_FULL_DIAG;
      // a short frame is dropped whole rather than half applied
      if (bit_cnt_r == quad_switch_pkg::BIT_CNT_FULL) begin
        case (cmd_kind(rx_r[quad_switch_pkg::CMD_HI:quad_switch_pkg::CMD_LO]))
          quad_switch_pkg::CMD_KIND_DIAG: begin
          end
          quad_switch_pkg::CMD_KIND_READ_BACK: begin
            mode_nxt = quad_switch_pkg::FRAME_READ_BACK;
          end
          quad_switch_pkg::CMD_KIND_ECHO: begin
            mode_nxt = quad_switch_pkg::FRAME_ECHO;
          end
          quad_switch_pkg::CMD_KIND_OR: begin
            and_nxt = 1'b0;
            data_nxt = rx_r[CHANNELS-1:0];
          end
          quad_switch_pkg::CMD_KIND_AND: begin
            and_nxt = 1'b1;
            data_nxt = rx_r[CHANNELS-1:0];
          end
          default: begin
            data_nxt = rx_r[CHANNELS-1:0];
          end
        endcase
      end
    end
    on_nxt = and_r ? (par_s & data_r) : (par_s | data_r);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      diag_r <= {CHANNELS{quad_switch_pkg::CODE_NORMAL}};
      rx_r <= '0;
      tx_r <= '0;
      bit_cnt_r <= quad_switch_pkg::BIT_CNT_ZERO;
      so_r <= 1'b0;
      and_r <= 1'b0;
      data_r <= '0;
      on_r <= '0;
      mode_r <= quad_switch_pkg::FRAME_FULL_DIAG;
    end else begin
      diag_r <= diag_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      so_r <= so_nxt;
      and_r <= and_nxt;
      data_r <= data_nxt;
      on_r <= on_nxt;
      mode_r <= mode_nxt;
    end
  end

  // ----------------------------------------
  // pins
  // ----------------------------------------
  assign so_oe = !cs_s;
  assign so_out = (mode_r == quad_switch_pkg::FRAME_ECHO) ? si_s : so_r;
  assign fault_out = 1'b0;
  assign fault_oe = any_fault;
  assign channel_on = on_r;
  assign and_mode = and_r;

endmodule

//--- tb/quad_switch_spi_diagnosis_chk.sv
// pin-level assertions for the quad switch diagnosis block
`timescale 1ns/10ps
module quad_switch_spi_diagnosis_chk #(
  parameter int CHANNELS = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic parallel_input_ch1,
  input wire logic [CHANNELS-1:0] overload_det,
  input wire logic [CHANNELS-1:0] open_load_det,
  input wire logic [CHANNELS-1:0] short_gnd_det,
  input wire logic so_out,
  input wire logic so_oe,
  input wire logic fault_out,
  input wire logic fault_oe,
  input wire logic [CHANNELS-1:0] channel_on,
  input wire logic and_mode
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_det;
    (|(overload_det | open_load_det | short_gnd_det))[*6];
  endsequence
  sequence s_quiet;
    (!(|(overload_det | open_load_det | short_gnd_det)))[*6];
  endsequence
  a_so_release: assert property (cs_n[*4] |-> !so_oe)
    else $error("serial output driven while deselected");
  a_so_drive: assert property ((!cs_n)[*4] |-> so_oe)
    else $error("serial output not driven in frame");
  a_so_hold: assert property ((!cs_n && !sclk)[*5] |-> $stable(so_out))
    else $error("serial output moved without clock rise");
  a_fault_set: assert property (s_det |-> fault_oe)
    else $error("fault pin not pulled on error");
  a_fault_pin: assert property (fault_out == 1'b0)
    else $error("fault pin driven high");
  a_fault_clear: assert property (s_quiet ##0 $rose(cs_n) |-> ##[1:6] !fault_oe)
    else $error("fault pin not released");
  a_reset_mode: assert property ($rose(rst_n) |-> !and_mode && channel_on == '0)
    else $error("wrong mode after reset");
  a_mode_frame: assert property (!$stable(and_mode) |-> cs_n)
    else $error("mode changed inside a frame");
  a_or_ch1: assert property ((!and_mode && parallel_input_ch1)[*4] |-> channel_on[0])
    else $error("or mode lost parallel input");
  a_and_ch1: assert property ((and_mode && !parallel_input_ch1)[*4] |-> !channel_on[0])
    else $error("and mode ignored parallel input");
endmodule
bind quad_switch_spi_diagnosis quad_switch_spi_diagnosis_chk #(.CHANNELS(CHANNELS))
  quad_switch_spi_diagnosis_chk_inst (.ref_clk, .rst_n, .cs_n, .sclk, .parallel_input_ch1,
  .overload_det, .open_load_det, .short_gnd_det, .so_out, .so_oe, .fault_out, .fault_oe,
  .channel_on, .and_mode);

//--- tb/spi_master_model.sv
// serial bus master model, clock idles low between frames
`timescale 1ns/10ps
module spi_master_model (
  input wire logic ref_clk,
  input wire logic so_line,
  output logic cs_n,
  output logic sclk,
  output logic si
);
  // ----------------------------------------
  // frame transfer, 160 ns clock period
  // ----------------------------------------
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  task automatic half();
    repeat (8) @(posedge ref_clk);
    #1;
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    half();
    cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      half();
      si = tx[i];
      rx[i] = so_line;
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    half();
    cs_n = 1'b1;
    half();
  endtask
endmodule

//--- tb/quad_switch_spi_diagnosis_tb.sv
// self-checking bench for the quad switch diagnosis block
`timescale 1ns/10ps
module quad_switch_spi_diagnosis_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] par = 4'h0;
  logic [3:0] ovl = 4'h0;
  logic [3:0] opn = 4'h0;
  logic [3:0] sgd = 4'h0;
  logic [3:0] chon;
  logic cs_n, sclk, si, so_out, so_oe, fault_out, fault_oe, and_mode;
  logic so_last = 1'b0;
  int bad_count = 0;
  int comparisons = 0;
  // released line shows the inverse so a stale bit cannot pass
  wire so_line = so_oe ? so_out : ~so_last;
  wire fault_line = fault_oe ? fault_out : 1'b1;
  always @(posedge ref_clk) if (so_oe) so_last <= so_out;
  quad_switch_spi_diagnosis quad_switch_spi_diagnosis_inst (.ref_clk, .rst_n, .cs_n, .sclk,
    .si, .parallel_input_ch1(par[0]), .parallel_input_ch2(par[1]),
    .parallel_input_ch3(par[2]), .parallel_input_ch4(par[3]), .overload_det(ovl),
    .open_load_det(opn), .short_gnd_det(sgd), .so_out, .so_oe, .fault_out, .fault_oe,
    .channel_on(chon), .and_mode);
  spi_master_model m (.ref_clk, .so_line, .cs_n, .sclk, .si);
  // ----------------------------------------
  // helpers and tests
  // ----------------------------------------
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic t_codes();
    logic [7:0] rx;
    ovl = 4'h1;
    opn = 4'h2;
    sgd = 4'h4;
    tick(10);
    chk({7'h0, fault_line}, 8'h00);
    m.xfer(8'h00, rx);
    m.xfer(8'h00, rx);
    chk(rx, 8'hc6);
    {ovl, opn, sgd} = 12'h000;
    tick(10);
    m.xfer(8'h00, rx);
    chk(rx, 8'hc6);
    m.xfer(8'h00, rx);
    chk(rx, 8'hff);
    chk({7'h0, fault_line}, 8'h01);
    opn = 4'h1;
    tick(10);
    opn = 4'h0;
    ovl = 4'h1;
    tick(10);
    ovl = 4'h0;
    m.xfer(8'h00, rx);
    chk(rx, 8'hfe);
    m.xfer(8'h00, rx);
    chk(rx, 8'hff);
    $display("codes test done");
  endtask
  task automatic t_modes();
    logic [7:0] rx;
    chk({3'h0, and_mode, chon}, 8'h00);
    par = 4'h9;
    m.xfer(8'h36, rx);
    chk({3'h0, and_mode, chon}, 8'h0f);
    m.xfer(8'hf3, rx);
    chk({3'h0, and_mode, chon}, 8'h11);
    par = 4'h8;
    tick(6);
    chk({3'h0, and_mode, chon}, 8'h10);
    par = 4'h9;
    m.xfer(8'h99, rx);
    chk({3'h0, and_mode, chon}, 8'h19);
    m.xfer(8'h00, rx);
    chk({3'h0, and_mode, chon}, 8'h19);
    m.xfer(8'h30, rx);
    chk({3'h0, and_mode, chon}, 8'h09);
    m.xfer(8'hc0, rx);
    m.xfer(8'h00, rx);
    chk(rx, 8'h9f);
    m.xfer(8'ha0, rx);
    m.xfer(8'h5a, rx);
    chk(rx, 8'h2d);
    m.xfer(8'hf0, rx);
    rst_n = 1'b0;
    tick(3);
    rst_n = 1'b1;
    tick(2);
    chk({7'h0, and_mode}, 8'h00);
    $display("modes test done");
  endtask
  // 16 frames of about 150 cycles each; the limit leaves wide margin
  initial begin
    #500us;
    bad_count++;
    results();
  end
  initial begin
    tick(12);
    rst_n = 1'b1;
    tick(8);
    t_modes();
    t_codes();
    results();
  end
endmodule
